// [rtl/ldt_pkg.sv]
// Package: constants for the ladder delay timer block
package ldt_pkg;
    // Element layout: three words per element, 40 elements in the timer file
    localparam int unsigned WORDS_PER_ELEM   = 3;
    localparam int unsigned NUM_ELEMS        = 40;
    localparam int unsigned NUM_WORDS        = WORDS_PER_ELEM * NUM_ELEMS;
    localparam int unsigned TIMER_FILE_NUM   = 4;
    // Word indexes within an element (byte address = 4 * index)
    localparam logic [1:0]  IDX_CONTROL      = 2'h0;
    localparam logic [1:0]  IDX_PRESET       = 2'h1;
    localparam logic [1:0]  IDX_ACCUM        = 2'h2;
    // Block status register index, after the timer words
    localparam logic [7:0]  IDX_STATUS       = 8'h80;
    // Control word fields
    localparam int unsigned BIT_ENABLE       = 15;
    localparam int unsigned BIT_TIMING       = 14;
    localparam int unsigned BIT_DONE         = 13;
    localparam int unsigned BIT_BASE_1S      = 1;
    localparam int unsigned BIT_OFF_DELAY    = 0;
    localparam int unsigned BIT_SIGN         = 15;
    // Status register fields
    localparam int unsigned BIT_ST_ERROR     = 0;
    localparam int unsigned BIT_ST_RUN       = 1;
    // Timebases
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned BASE_FAST_MS     = 10;
    localparam int unsigned BASE_SLOW_MS     = 1000;
    localparam int unsigned TICK_FAST_CYCLES = BASE_FAST_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned FAST_PER_SLOW    = BASE_SLOW_MS / BASE_FAST_MS;
    localparam int unsigned STAMP_W          = 8;
endpackage : ldt_pkg

// [rtl/ldt_timer.sv]
// Module: timer file with on-delay/off-delay evaluation and APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - Element is control, preset, accumulator words
// - Values 0..32767; negative gives runtime error
// - Tick period selectable 10 ms or 1 s
// - On-delay done when accumulator reaches or exceeds preset
// - On-delay counts while rung true
// - On-delay clears accumulator when rung false
// - On-delay enable, timing, done flag behaviour
// - On-delay holds state outside run mode
// - On-delay return to run clears accumulator
// - Off-delay counts after rung goes false
// - Off-delay clears accumulator when rung true
// - Off-delay done set while rung true
// - Off-delay timing while false and below preset
// - Off-delay enable follows rung
// - Off-delay holds state outside run mode
// - Off-delay return to run fixes flags
// - Off-delay keeps timing in inactive zone
// - Exact tick counting keeps timing error bounded
// - Elements 0 to 39 of file 4
module ldt_timer #(
    parameter int unsigned TICK_CYCLES = ldt_pkg::TICK_FAST_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Program scan request
    input  wire logic        scan_req,
    input  wire logic [5:0]  scan_elem,
    input  wire logic        scan_rung,
    input  wire logic        zone_inactive,
    input  wire logic        run_mode,
    // Scan answer
    output logic             scan_done,
    output logic             enable_out,
    output logic             timing_out,
    output logic             done_flag,
    output logic             runtime_error
);
    // Block organisation:
    // The timer file is one flat array of 16-bit words, three per element.
    // Software fills control and preset words over the bus before use.
    // The program scan evaluates one element per request on the scan port.
    // A scan reads the three words, works out new flags and count,
    // and writes control and count back at the edge that answers it.
    // Only one element is evaluated per cycle, so one evaluator is shared
    // by all forty elements instead of forty copies of the same logic.
    // Storage: timer words, per-element tick stamps, return-to-run marks
    logic [15:0]                     tmr_mem [0:ldt_pkg::NUM_WORDS-1];
    logic [ldt_pkg::STAMP_W-1:0]     stamp   [0:ldt_pkg::NUM_ELEMS-1];
    logic [ldt_pkg::NUM_ELEMS-1:0]   ret_pending;
    logic                            run_q;
    logic                            error_sticky;

    // Tick generation:
    // One divider makes the fast tick from the system clock.
    // The slow tick is every hundredth fast tick, so both bases stay aligned.
    // Two small tick counters act as clocks that every element stamps.
    // Keeping the dividers global rather than per element saves area,
    // at the cost of a phase of up to one tick at the start of an interval.
    // Tick generation
    logic [31:0]                     tick_div;
    logic [7:0]                      slow_div;
    logic [ldt_pkg::STAMP_W-1:0]     fast_cnt;
    logic [ldt_pkg::STAMP_W-1:0]     slow_cnt;
    wire                             fast_tick = (tick_div == TICK_CYCLES - 1);
    wire                             slow_tick = fast_tick
                                        && (slow_div == 8'(ldt_pkg::FAST_PER_SLOW - 1));

    // Free-running timebase counters; exact division keeps error within one tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_div <= 32'h0;
            slow_div <= 8'h0;
            fast_cnt <= '0;
            slow_cnt <= '0;
        end else begin
            tick_div <= fast_tick ? 32'h0 : tick_div + 32'h1;
            if (fast_tick) begin
                slow_div <= slow_tick ? 8'h0 : slow_div + 8'h1;
                fast_cnt <= fast_cnt + 1'b1;
            end
            if (slow_tick) begin
                slow_cnt <= slow_cnt + 1'b1;
            end
        end
    end

    // Element addressing:
    // Word index is three times the element number plus the word offset.
    // Element numbers above the last one read as zero and are never written.
    // The product is kept at seven bits, enough for all word indexes.
    // Element addressing: three words per element
    wire [6:0]  elem_base = 7'({1'b0, scan_elem} * 7'(ldt_pkg::WORDS_PER_ELEM));
    wire        elem_ok   = (scan_elem < 6'(ldt_pkg::NUM_ELEMS));
    wire [6:0]  ctl_idx   = elem_base + 7'(ldt_pkg::IDX_CONTROL);
    wire [6:0]  pre_idx   = elem_base + 7'(ldt_pkg::IDX_PRESET);
    wire [6:0]  acc_idx   = elem_base + 7'(ldt_pkg::IDX_ACCUM);
    wire [15:0] ctl_w     = elem_ok ? tmr_mem[ctl_idx] : 16'h0;
    wire [15:0] pre_w     = elem_ok ? tmr_mem[pre_idx] : 16'h0;
    wire [15:0] acc_w     = elem_ok ? tmr_mem[acc_idx] : 16'h0;
    wire [ldt_pkg::STAMP_W-1:0] old_stamp = elem_ok ? stamp[scan_elem] : '0;

    // Decoding of the addressed element:
    // Mode and timebase are software bits in the low end of the control word.
    // A set sign bit in preset or count marks a value outside the legal range.
    // Decoded element state
    wire        off_mode  = ctl_w[ldt_pkg::BIT_OFF_DELAY];
    wire        base_slow = ctl_w[ldt_pkg::BIT_BASE_1S];
    wire        en_q      = ctl_w[ldt_pkg::BIT_ENABLE];
    wire        tt_q      = ctl_w[ldt_pkg::BIT_TIMING];
    wire        dn_q      = ctl_w[ldt_pkg::BIT_DONE];
    wire        negative  = pre_w[ldt_pkg::BIT_SIGN] | acc_w[ldt_pkg::BIT_SIGN];
    // Inactive zone forces the rung false, so off-delay keeps timing there
    wire        rung      = scan_rung & ~zone_inactive;
    wire        returning = elem_ok && ret_pending[scan_elem];

    // Elapsed time:
    // Each element keeps the tick counter value of its previous scan.
    // The difference to the current value is the number of whole ticks
    // that passed, so a slow scan still adds the full elapsed time.
    // Gaps longer than the stamp range wrap and are lost without notice.
    // Elapsed ticks since this element was last scanned
    wire [ldt_pkg::STAMP_W-1:0] now_stamp = base_slow ? slow_cnt : fast_cnt;
    wire [ldt_pkg::STAMP_W-1:0] delta     = now_stamp - old_stamp;
    wire [16:0] acc_sum   = {1'b0, acc_w} + {9'h0, delta};
    wire [15:0] acc_run   = (acc_sum >= {1'b0, pre_w}) ? pre_w : acc_sum[15:0];
    wire [15:0] acc_adv   = (acc_w >= pre_w) ? acc_w : acc_run;

    // Evaluation order:
    // Bad values come first and leave the element as it was.
    // The first scan after entering run mode applies the return fix-up
    // and nothing else, so a stale count from program mode never runs on.
    // After that, on-delay counts while the rung is true and clears on false;
    // off-delay counts while the rung is false and clears on true.
    // Done is worked out from the new count, so on-delay done rises, and off-delay done falls,
    // on the same scan on which the count reaches the preset.
    // The count never passes the preset, which keeps it inside its range.
    // Next-state evaluation of one element
    logic [15:0] next_ctl;
    logic [15:0] next_acc;
    logic        next_en;
    logic        next_tt;
    logic        next_dn;
    always_comb begin
        next_en  = en_q;
        next_tt  = tt_q;
        next_dn  = dn_q;
        next_acc = acc_w;
        if (negative) begin
            // Bad values: element left untouched, error raised
            next_acc = acc_w;
        end else if (returning && !off_mode) begin
            next_acc = 16'h0;
            next_en  = en_q & rung;
            next_tt  = tt_q & rung;
            next_dn  = dn_q & rung;
        end else if (returning) begin
            next_tt  = 1'b0;
            next_en  = rung;
            next_dn  = rung;
            next_acc = rung ? 16'h0 : pre_w;
        end else if (!off_mode) begin
            if (!rung) begin
                next_acc = 16'h0;
                next_en  = 1'b0;
                next_tt  = 1'b0;
                next_dn  = 1'b0;
            end else begin
                // Counting starts on the scan where the rung first goes true
                next_acc = en_q ? acc_adv : acc_w;
                next_en  = 1'b1;
                next_dn  = (next_acc >= pre_w);
                next_tt  = ~next_dn;
            end
        end else begin
            if (rung) begin
                next_acc = 16'h0;
                next_en  = 1'b1;
                next_dn  = 1'b1;
                next_tt  = 1'b0;
            end else begin
                next_en  = 1'b0;
                if (en_q) begin
                    next_acc = 16'h0;
                end else if (dn_q) begin
                    next_acc = acc_adv;
                end
                next_dn  = dn_q && (next_acc < pre_w);
                next_tt  = next_dn;
            end
        end
        next_ctl = ctl_w;
        next_ctl[ldt_pkg::BIT_ENABLE] = next_en;
        next_ctl[ldt_pkg::BIT_TIMING] = next_tt;
        next_ctl[ldt_pkg::BIT_DONE]   = next_dn;
    end

    // Scan acceptance:
    // A scan outside run mode or of a missing element still gets its answer
    // pulse, but the element and the flag outputs stay as they were.
    // Scans only act in run/test mode; in program mode everything is held
    wire eval_go  = scan_req && run_mode && elem_ok;
    wire eval_err = eval_go && negative;

    // Register map:
    // Timer words sit at word indexes 0 to 119, one word per bus address.
    // The block status word sits at index 0x80, past the timer words.
    // Upper halves of timer words read as zero and ignore writes.
    // Any other address answers with an error and changes nothing.
    // A transfer takes effect only at the edge where ready is seen high.
    // APB decode
    wire [7:0]  reg_idx    = paddr[9:2];
    wire        hit_timer  = (paddr[11:10] == 2'h0) && (reg_idx < 8'(ldt_pkg::NUM_WORDS));
    wire        hit_status = (paddr[11:10] == 2'h0) && (reg_idx == ldt_pkg::IDX_STATUS);
    wire        apb_done   = psel && penable && pready;
    wire        apb_wr     = apb_done && pwrite;
    wire        wr_timer   = apb_wr && hit_timer;
    wire        clr_error  = apb_wr && hit_status && pwdata[ldt_pkg::BIT_ST_ERROR];
    wire [15:0] rd_word    = hit_timer ? tmr_mem[7'(reg_idx)] : 16'h0;
    wire [31:0] rd_status  = {30'h0, run_mode, error_sticky};
    wire [31:0] next_rdata = hit_timer ? {16'h0, rd_word}
                           : hit_status ? rd_status : 32'h0;

    // Word storage:
    // Each word has its own register with one write port for the bus
    // and one for the scan update; the scan only touches control and count.
    // The preset is written by software alone.
    // Timer word storage: no reset so contents survive a reset like power loss.
    // A bus write completing in the same cycle as a scan of that word wins.
    genvar gw;
    generate
        for (gw = 0; gw < ldt_pkg::NUM_WORDS; gw++) begin : g_word
            wire scan_hit = eval_go && !negative
                            && ((7'(gw) == ctl_idx) || (7'(gw) == acc_idx));
            always_ff @(posedge clk) begin
                if (wr_timer && (7'(reg_idx) == 7'(gw))) begin
                    tmr_mem[gw] <= pwdata[15:0];
                end else if (scan_hit) begin
                    tmr_mem[gw] <= (7'(gw) == ctl_idx) ? next_ctl : next_acc;
                end
            end
        end
    endgenerate

    // Per-element bookkeeping:
    // A scan that raised an error keeps its mark, so the fix-up is applied
    // once the values are repaired.
    // Per-element stamp and return-to-run mark
    genvar ge;
    generate
        for (ge = 0; ge < ldt_pkg::NUM_ELEMS; ge++) begin : g_elem
            wire this_scan = eval_go && (scan_elem == 6'(ge));
            always_ff @(posedge clk) begin
                if (this_scan) begin
                    stamp[ge] <= now_stamp;
                end
            end
            // Entering run mode marks every element for its fix-up scan
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ret_pending[ge] <= 1'b1;
                end else if (run_mode && !run_q) begin
                    ret_pending[ge] <= 1'b1;
                end else if (this_scan && !negative) begin
                    ret_pending[ge] <= 1'b0;
                end
            end
        end
    endgenerate

    // Bus answer:
    // Registering ready costs one wait state but keeps decode off the
    // output path. Read data stands only with ready and is zero otherwise,
    // so the closing edge of a transfer must not load it again.
    // APB response: one wait state, then pready for one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pwrite && !pready) ? next_rdata : 32'h0;
            pslverr <= psel && penable && !pready && !hit_timer && !hit_status;
        end
    end

    // Mode and error status:
    // The run mode edge arms the fix-up for every element at once.
    // Run mode edge and sticky error; a new error beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q        <= 1'b0;
            error_sticky <= 1'b0;
        end else begin
            run_q        <= run_mode;
            error_sticky <= eval_err | (error_sticky & ~clr_error);
        end
    end

    // Scan answer:
    // The answer pulse follows every request one cycle later.
    // Flag outputs change only on an accepted scan and hold otherwise,
    // so the program can read them at leisure.
    // Scan answer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_done     <= 1'b0;
            enable_out    <= 1'b0;
            timing_out    <= 1'b0;
            done_flag     <= 1'b0;
            runtime_error <= 1'b0;
        end else begin
            scan_done     <= scan_req;
            runtime_error <= eval_err;
            if (eval_go) begin
                enable_out <= next_en;
                timing_out <= next_tt;
                done_flag  <= next_dn;
            end
        end
    end
endmodule : ldt_timer

// [test/ldt_scan_src.sv]
// Partner: program scan that evaluates one timer element per request
`timescale 1ns/1ps
module ldt_scan_src (
    // Clock
    input wire logic   clk,
    // Scan request
    output logic       scan_req,
    output logic [5:0] scan_elem,
    output logic       scan_rung,
    output logic       zone_inactive
);
    // Idle lines; this program has no reset operation to misuse
    initial begin
        scan_req      = 1'b0;
        scan_elem     = 6'h3F;
        scan_rung     = 1'b0;
        zone_inactive = 1'b0;
    end
    // One request; returns at the edge where the answer is sampled
    task automatic scan(input logic [5:0] e, input logic r, input logic z);
        scan_req      <= 1'b1;
        scan_elem     <= e;
        scan_rung     <= r;
        zone_inactive <= z;
        @(posedge clk);
        scan_req      <= 1'b0;
        scan_elem     <= ~e; // Stale element number is not held
        @(posedge clk);
    endtask : scan
endmodule : ldt_scan_src

// [test/ldt_timer_assertions.sv]
// Checker: port timing relations of the ladder delay timer
`timescale 1ns/1ps
module ldt_timer_chk (
    // Bus side
    input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Scan side
    input wire logic        scan_req, scan_rung, zone_inactive, run_mode,
    input wire logic [5:0]  scan_elem,
    input wire logic        scan_done, enable_out, timing_out, done_flag, runtime_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_scan_answer: assert property (scan_req |=> scan_done)
        else $error("scan without answer");
    a_no_stray_done: assert property (!scan_req |=> !scan_done)
        else $error("answer without scan");
    a_flags_hold: assert property (!scan_req |=> $stable({enable_out, timing_out, done_flag}))
        else $error("flags moved without scan");
    a_program_hold: assert property (scan_req && !run_mode |=> $stable({enable_out, timing_out, done_flag}))
        else $error("flags moved in program mode");
    a_enable_rung: assert property (scan_req && run_mode && scan_elem < 6'd40 |=>
        runtime_error || enable_out == ($past(scan_rung) && !$past(zone_inactive)))
        else $error("enable does not follow rung");
    a_error_scan: assert property (runtime_error |-> scan_done && $past(scan_req))
        else $error("error pulse without scan");
    a_bus_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    a_bus_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_bus_refuse: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_read_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    // Main scenarios reached
    c_error: cover property (runtime_error);
    c_timing: cover property ($rose(timing_out));
    c_refuse: cover property (pslverr);
endmodule : ldt_timer_chk

bind ldt_timer ldt_timer_chk u_chk (.*);

// [test/tb_ladder_delay_timer.sv]
// Testbench: register access and both timer modes through bus and scan port
`timescale 1ns/1ps
module tb_ladder_delay_timer;
    localparam int TK = 10; // Short tick keeps the run brief
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run_mode = 1, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, a;
    logic        pready, pslverr, scan_req, scan_rung, zone_inactive, scan_done;
    logic        enable_out, timing_out, done_flag, runtime_error;
    logic [5:0]  scan_elem;
    int          n_mismatch = 0, total_checks = 0, pre, k, mdl[4];
    // Free-running clock
    always #2 clk = ~clk;
    ldt_scan_src src (.*);
    ldt_timer #(.TICK_CYCLES(TK)) dut (.*);
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict
    task automatic end_sim;
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // One bus transfer on word index i, held until pready is seen at an edge
    task automatic apb(input logic w, input int i, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= 12'(i * 4);
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin
            n_mismatch++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask : apb
    // Scan, then compare enable, timing and done
    task automatic sc(input int e, input logic r, input logic z, input logic [2:0] f);
        src.scan(6'(e), r, z);
        chk({scan_done, enable_out, timing_out, done_flag}, {1'b1, f});
    endtask : sc
    // Main sequence
    initial begin
        void'($urandom(94));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Random words keep only their low half; model holds the expectation
        for (k = 0; k < 4; k++) begin
            mdl[k] = $urandom & 32'hFFFF;
            apb(1, k < 3 ? k : 119, $urandom & 32'hFFFF0000 | mdl[k]);
        end
        for (k = 0; k < 4; k++) begin
            apb(0, k < 3 ? k : 119, 32'h0);
            chk(rd, mdl[k]);
        end
        apb(0, 120, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        // On-delay counts to preset, pacing stays far below 2.5 s
        pre = 6 + $urandom % 4;
        apb(1, 0, 32'h0);
        apb(1, 1, pre);
        apb(1, 2, 32'h0);
        sc(0, 0, 0, 3'b000);
        sc(0, 1, 0, 3'b110);
        for (k = 1; k < 20 && done_flag !== 1'b1; k++) begin
            repeat (2 * TK - 2) @(posedge clk);
            src.scan(0, 1, 0);
        end
        chk(32'(2 * k - 1 >= pre && 2 * k - 5 < pre), 32'h1);
        sc(0, 1, 0, 3'b101);
        apb(0, 2, 32'h0);
        chk(rd, pre);
        apb(0, 0, 32'h0);
        chk(rd, 32'hA000);
        sc(0, 0, 0, 3'b000);
        apb(0, 2, 32'h0);
        chk(rd, 32'h0);
        // Program mode mid-interval holds; return to run restarts the count
        sc(0, 1, 0, 3'b110);
        repeat (40) @(posedge clk);
        run_mode <= 1'b0;
        sc(0, 0, 0, 3'b110);
        apb(0, 2, 32'h0);
        chk(rd, 32'h0);
        run_mode <= 1'b1;
        @(posedge clk);
        sc(0, 1, 0, 3'b110);
        // Off-delay: done while true, inactive zone starts timing
        apb(1, 3, 32'h1);
        apb(1, 4, 32'h4);
        apb(1, 5, 32'h0);
        sc(1, 1, 0, 3'b101);
        sc(1, 1, 1, 3'b011);
        for (k = 0; k < 20 && done_flag === 1'b1; k++) begin
            repeat (2 * TK - 2) @(posedge clk);
            src.scan(1, 0, 0);
        end
        chk({enable_out, timing_out, done_flag}, 3'b000);
        apb(0, 5, 32'h0);
        chk(rd, 32'h4);
        sc(1, 1, 0, 3'b101);
        apb(0, 5, 32'h0);
        chk(rd, 32'h0);
        sc(1, 0, 0, 3'b011);
        run_mode <= 1'b0;
        sc(1, 1, 0, 3'b011);
        run_mode <= 1'b1;
        @(posedge clk);
        sc(1, 0, 0, 3'b000);
        apb(0, 5, 32'h0);
        chk(rd, 32'h4);
        // Negative preset raises error; sticky status clears by writing one
        apb(1, 9, 32'h0);
        apb(1, 10, 32'h8000);
        src.scan(3, 1, 0);
        chk(runtime_error, 1'b1);
        apb(1, 128, 32'h1);
        apb(0, 128, 32'h0);
        chk(rd[1:0], 2'h2);
        end_sim();
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule : tb_ladder_delay_timer
